// ---- ffme_axis_cmp.sv ----
// ffme_axis_cmp: magnitude-versus-threshold test for one acceleration axis.
// assumes two's-complement samples and an unsigned threshold of ffme_pkg width.
`timescale 1ns/10ps
module ffme_axis_cmp #(
  parameter int DATA_W = ffme_pkg::FFME_DATA_W
) (
  input  wire logic signed [DATA_W-1:0]            sample,
  input  wire logic [ffme_pkg::FFME_THR_W-1:0]     thr,
  input  wire logic                                motion_mode,
  output logic                                     hit,
  output logic                                     neg
);
  import ffme_pkg::*;

  logic [DATA_W-1:0] mag;

  // magnitude is one bit wider than the threshold can express, so the most
  // negative code still compares correctly as a large value
  assign mag = sample[DATA_W-1] ? DATA_W'(-sample) : DATA_W'(sample);
  assign neg = sample[DATA_W-1];
  assign hit = motion_mode ? (mag > DATA_W'(thr)) : (mag < DATA_W'(thr));

endmodule

// ---- ffme_event.sv ----
// ffme_event: freefall/motion event detector with its register file.
// assumes one sample_valid pulse per new acceleration sample, synchronous to core_clk,
// and a byte register port where a read answers on the next edge.
//
// Operation
// - source register is read-only; host writes leave event flags untouched
// - event-active sets when the selected axis combination is true and the debounce count reaches the count limit at 0x18
// - interrupt is event-active gated by enable, steered by routing bit
// - bit 7 reads event-active: 1 once the debounced axis combination has set it, else 0
// - bit 5 is Z high event, zero while Z detection disabled
// - bit 4 is Z polarity, 1 negative, zero while Z disabled
// - bit 3 is Y high event, zero while Y detection disabled
// - bit 2 is Y polarity, 1 negative, zero while Y disabled
// - bit 1 is X high event, zero while X detection disabled
// - bit 0 is X polarity, 1 negative, zero while X disabled
// - threshold bit 7 picks debounce clear mode in every threshold mode
// - clear mode one zeroes the debounce counter on a non-matching sample
// - clear mode zero decrements per non-matching sample, stopping at zero
// - common threshold in bits 6:0 at 0x17, resets zero, 63 mg per count
// - per-axis thresholds at 0x73..0x78; 0x73 holds select and X high bits
// - logic select zero gives freefall AND, one gives motion OR
// - with latch enabled flags freeze on event-active; source read clears
// - per-axis select one compares each axis with its own 13-bit threshold
// - freefall needs every enabled axis below; motion any enabled axis above
`timescale 1ns/10ps
module ffme_event #(
  parameter int DATA_W = ffme_pkg::FFME_DATA_W
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     sample_valid,
  input  wire logic signed [DATA_W-1:0] accel_x,
  input  wire logic signed [DATA_W-1:0] accel_y,
  input  wire logic signed [DATA_W-1:0] accel_z,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     int_enable,
  input  wire logic                     int_route,
  output logic [7:0]                    reg_rdata,
  output logic                          irq_int1,
  output logic                          irq_int2,
  output logic                          event_active_flag
);
  import ffme_pkg::*;

  if (DATA_W <= FFME_THR_W) begin : g_width_check
    $error("ffme_event: DATA_W must exceed the 13-bit threshold width");
  end

  typedef struct packed {
    logic [7:0]                         cfg;
    logic                               ea;
    logic [2*FFME_AXES-1:0]             flags;
    logic [7:0]                         ths;
    logic [7:0]                         cnt_lim;
    logic [7:0]                         dbc;
    logic [FFME_AXTHR_REGS-1:0][7:0]    axthr;
    logic [7:0]                         rdata;
    logic                               irq1;
    logic                               irq2;
  } ffme_state_t;

  ffme_state_t r;
  ffme_state_t next_r;

  logic signed [FFME_AXES-1:0][DATA_W-1:0]     sample;
  logic [FFME_AXES-1:0][FFME_THR_W-1:0]        thr;
  logic [FFME_AXES-1:0]                        hit;
  logic [FFME_AXES-1:0]                        neg;
  logic [FFME_AXES-1:0]                        axis_en;
  logic                                        per_axis;
  logic                                        motion;
  logic                                        cond;
  logic                                        src_read;
  logic [7:0]                                  dbc_step;
  logic                                        ea_new;
  logic [2*FFME_AXES-1:0]                      live_flags;
  logic [2*FFME_AXES-1:0]                      flag_mask;

  assign sample[0] = accel_x;
  assign sample[1] = accel_y;
  assign sample[2] = accel_z;
  assign per_axis  = r.axthr[0][FFME_AXTHR_SEL];
  assign motion    = r.cfg[FFME_CFG_MOTION];
  assign src_read  = reg_rd && (reg_addr == FFME_SRC_OFS);

  for (genvar i = 0; i < FFME_AXES; i++) begin : g_axis
    assign axis_en[i] = r.cfg[FFME_CFG_XEN+i];
    // common threshold occupies the same high bits as a per-axis threshold
    assign thr[i] = per_axis ?
      {r.axthr[2*i][FFME_AXTHR_HI_W-1:0],
       r.axthr[2*i+1][FFME_AXTHR_LO_POS +: FFME_AXTHR_LO_W]} :
      {r.ths[FFME_THS_MSB:0], {FFME_AXTHR_LO_W{1'b0}}};
    assign live_flags[2*i+1] = axis_en[i] & hit[i];
    assign live_flags[2*i]   = axis_en[i] & neg[i];
    assign flag_mask[2*i+1]  = axis_en[i];
    assign flag_mask[2*i]    = axis_en[i];

    ffme_axis_cmp #(
      .DATA_W (DATA_W)
    ) u_cmp (
      .sample      (sample[i]),
      .thr         (thr[i]),
      .motion_mode (motion),
      .hit         (hit[i]),
      .neg         (neg[i])
    );
  end

  // freefall with no axis enabled never fires; a vacuous AND would look like a fall
  assign cond = motion ? |(hit & axis_en) :
                ((&(hit | ~axis_en)) && |axis_en);

  always_comb begin
    next_r   = r;
    dbc_step = r.dbc;
    ea_new   = 1'b0;

    if (reg_wr) begin
      unique case (reg_addr)
        FFME_CFG_OFS:   next_r.cfg     = reg_wdata;
        FFME_THS_OFS:   next_r.ths     = reg_wdata;
        FFME_COUNT_OFS: next_r.cnt_lim = reg_wdata;
        default: begin
          // source offset falls here and is ignored
          if (reg_addr >= FFME_AXTHR_FIRST && reg_addr <= FFME_AXTHR_LAST) begin
            next_r.axthr[3'(reg_addr - FFME_AXTHR_FIRST)] = reg_wdata;
          end
        end
      endcase
    end

    if (src_read && r.cfg[FFME_CFG_LATCH]) begin
      next_r.ea    = 1'b0;
      next_r.flags = '0;
    end

    if (sample_valid) begin
      if (cond) begin
        dbc_step = (r.dbc == FFME_DBC_MAX) ? r.dbc : 8'(r.dbc + 8'h01);
      end else if (r.ths[FFME_THS_DBCLR]) begin
        dbc_step = FFME_DBC_RST;
      end else if (r.dbc != FFME_DBC_RST) begin
        dbc_step = 8'(r.dbc - 8'h01);
      end
      next_r.dbc = dbc_step;
      ea_new = cond && (dbc_step >= r.cnt_lim);
      // a new sample in the clearing read cycle still lands: set beats clear
      if (!(r.cfg[FFME_CFG_LATCH] && r.ea) || src_read) begin
        next_r.ea    = ea_new;
        next_r.flags = live_flags;
      end
    end

    next_r.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        FFME_CFG_OFS:   next_r.rdata = r.cfg;
        // disabled axes read zero even if flags were captured before disabling
        FFME_SRC_OFS:   next_r.rdata = {r.ea, 1'b0, r.flags & flag_mask};
        FFME_THS_OFS:   next_r.rdata = r.ths;
        FFME_COUNT_OFS: next_r.rdata = r.cnt_lim;
        default: begin
          if (reg_addr >= FFME_AXTHR_FIRST && reg_addr <= FFME_AXTHR_LAST) begin
            next_r.rdata = r.axthr[3'(reg_addr - FFME_AXTHR_FIRST)];
          end
        end
      endcase
    end

    next_r.irq1 = next_r.ea && int_enable && int_route;
    next_r.irq2 = next_r.ea && int_enable && !int_route;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata         = r.rdata;
  assign irq_int1          = r.irq1;
  assign irq_int2          = r.irq2;
  assign event_active_flag = r.ea;

  default clocking ffme_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_src_write_ignored: assert property (
    reg_wr && reg_addr == FFME_SRC_OFS && !sample_valid && !src_read
    |=> $stable({r.ea, r.flags}))
    else $error("source register changed by a host write");

  a_ea_sets_on_count: assert property (
    sample_valid && cond && !(r.cfg[FFME_CFG_LATCH] && r.ea) && r.dbc >= r.cnt_lim
    |=> r.ea)
    else $error("event-active not set on matching debounced sample");

  a_ea_needs_count: assert property (
    sample_valid && !r.ea && cond && 9'(r.dbc) + 9'h001 < 9'(r.cnt_lim)
    |=> !r.ea)
    else $error("event-active set before debounce count reached");

  a_irq_gating: assert property (
    ##1 (irq_int1 == (r.ea && $past(int_enable) && $past(int_route))) &&
        (irq_int2 == (r.ea && $past(int_enable) && !$past(int_route))))
    else $error("interrupt outputs disagree with event-active gating");

  a_ea_read_bit: assert property (
    src_read |=> reg_rdata[FFME_SRC_EA] == $past(r.ea))
    else $error("bit 7 of source read differs from event-active");

  a_z_masked_read: assert property (
    src_read && !axis_en[2] |=> reg_rdata[5:4] == 2'h0)
    else $error("Z flags read nonzero while Z disabled");

  a_y_masked_read: assert property (
    src_read && !axis_en[1] |=> reg_rdata[3:2] == 2'h0)
    else $error("Y flags read nonzero while Y disabled");

  a_x_masked_read: assert property (
    src_read && !axis_en[0] |=> reg_rdata[1:0] == 2'h0)
    else $error("X flags read nonzero while X disabled");

  a_dbc_clear_mode: assert property (
    sample_valid && !cond && r.ths[FFME_THS_DBCLR] |=> r.dbc == 8'h00)
    else $error("debounce counter not cleared in clear mode");

  a_dbc_decrement: assert property (
    sample_valid && !cond && !r.ths[FFME_THS_DBCLR] && r.dbc != 8'h00
    |=> r.dbc == 8'($past(r.dbc) - 8'h01))
    else $error("debounce counter did not step down by one");

  a_latch_freeze: assert property (
    r.cfg[FFME_CFG_LATCH] && r.ea && !src_read |=> r.ea && $stable(r.flags))
    else $error("latched source flags changed before a source read");

  a_latch_read_clear: assert property (
    r.cfg[FFME_CFG_LATCH] && src_read && !sample_valid |=> !r.ea && r.flags == 6'h00)
    else $error("source read did not clear latched flags");

  // with no debounce and no latch, event-active must agree with the flags of the same sample
  a_combine_mode: assert property (
    sample_valid && r.cnt_lim == 8'h00 && !r.cfg[FFME_CFG_LATCH]
    |=> r.ea == ($past(motion) ? (r.flags[5] || r.flags[3] || r.flags[1]) :
                 ((r.flags[5] || !$past(axis_en[2])) && (r.flags[3] || !$past(axis_en[1])) &&
                  (r.flags[1] || !$past(axis_en[0])) && |$past(axis_en))))
    else $error("event condition not the selected axis combination");

  a_common_thr: assert property (
    !per_axis |-> thr[0] == {r.ths[6:0], 6'h00})
    else $error("common threshold not applied to X axis");

  a_per_axis_thr: assert property (
    per_axis |-> thr[0] == {r.axthr[0][6:0], r.axthr[1][7:2]} &&
                 thr[2] == {r.axthr[4][6:0], r.axthr[5][7:2]})
    else $error("per-axis threshold not assembled from its register pair");

  a_ths_write: assert property (
    reg_wr && reg_addr == FFME_THS_OFS |=> r.ths == $past(reg_wdata))
    else $error("threshold register did not take the written byte");

  a_axthr_sel: assert property (
    reg_wr && reg_addr == FFME_AXTHR_FIRST |=> per_axis == $past(reg_wdata[FFME_AXTHR_SEL]))
    else $error("per-axis select not taken from bit 7 of the first axis register");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero after a cycle without a read");

  a_dbc_increment: assert property (
    sample_valid && cond && r.dbc != 8'hff
    |=> r.dbc == 8'($past(r.dbc) + 8'h01))
    else $error("debounce counter did not step up on a matching sample");

  // a sample that lands in the clearing read cycle must not be lost
  a_ea_set_wins: assert property (
    sample_valid && src_read && r.cfg[FFME_CFG_LATCH] && cond && r.dbc >= r.cnt_lim |=> r.ea)
    else $error("read clear beat a matching sample in the same cycle");

  a_src_read_keeps: assert property (
    !r.cfg[FFME_CFG_LATCH] && src_read && !sample_valid |=> $stable({r.ea, r.flags}))
    else $error("source read changed flags with the latch disabled");

  // event-active only moves on a sample or on a latched read clear
  a_ea_hold: assert property (
    !sample_valid && !(src_read && r.cfg[FFME_CFG_LATCH]) |=> $stable(r.ea))
    else $error("event-active changed without a sample or read clear");

  a_x_polarity: assert property (
    sample_valid && !r.cfg[FFME_CFG_LATCH]
    |=> r.flags[0] == ($past(axis_en[0]) && $past(accel_x[DATA_W-1])))
    else $error("X polarity flag differs from the sample sign");

  a_irq_exclusive: assert property (
    !(irq_int1 && irq_int2))
    else $error("both interrupt outputs high at once");

  c_motion_event:   cover property (sample_valid && motion && cond ##1 r.ea);
  c_freefall_event: cover property (sample_valid && !motion && cond ##1 r.ea);
  c_latch_clear:    cover property (r.cfg[FFME_CFG_LATCH] && r.ea && src_read ##1 !r.ea);
  c_irq_fired:      cover property (irq_int1 || irq_int2);
  c_set_wins:       cover property (sample_valid && src_read && r.cfg[FFME_CFG_LATCH] ##1 r.ea);

endmodule

// ---- ffme_host.sv ----
// ffme_host: host-side register master for the freefall/motion event block.
// assumes strobes taken on core_clk rising edges and read data standing one cycle after.
`timescale 1ns/10ps
module ffme_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one access: strobe for one edge, then take the answer in the following cycle
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // idle lines show no stale value, so a design that samples them late is caught
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1 q = reg_rdata;
  endtask
endmodule

// ---- ffme_pkg.sv ----
// ffme_pkg: offsets, field positions and reset values of the freefall/motion event block.
// assumes an 8-bit register port addressed by byte offset, as on the serial interface.
package ffme_pkg;

  // register offsets
  localparam logic [7:0] FFME_CFG_OFS      = 8'h15;
  localparam logic [7:0] FFME_SRC_OFS      = 8'h16;
  localparam logic [7:0] FFME_THS_OFS      = 8'h17;
  localparam logic [7:0] FFME_COUNT_OFS    = 8'h18;
  localparam logic [7:0] FFME_AXTHR_FIRST  = 8'h73;
  localparam logic [7:0] FFME_AXTHR_LAST   = 8'h78;
  localparam int         FFME_AXTHR_REGS   = 6;

  // configuration register fields
  localparam int FFME_CFG_LATCH   = 7;
  localparam int FFME_CFG_MOTION  = 6;
  localparam int FFME_CFG_XEN     = 3;

  // source register fields; axis i uses bits 2i+1 (event) and 2i (polarity)
  localparam int FFME_SRC_EA      = 7;

  // threshold register fields
  localparam int FFME_THS_DBCLR   = 7;
  localparam int FFME_THS_MSB     = 6;

  // per-axis threshold fields
  localparam int FFME_AXTHR_SEL   = 7;
  localparam int FFME_AXTHR_HI_W  = 7;
  localparam int FFME_AXTHR_LO_W  = 6;
  localparam int FFME_AXTHR_LO_POS = 2;
  localparam int FFME_THR_W       = 13;

  // reset values and debounce counter ceiling
  localparam logic [7:0] FFME_REG_RST     = 8'h00;
  localparam logic [7:0] FFME_DBC_RST     = 8'h00;
  localparam logic [7:0] FFME_DBC_MAX     = 8'hff;

  // common threshold resolution, milli-g per count
  localparam int FFME_THS_MG_PER_LSB = 63;

  localparam int FFME_AXES        = 3;
  localparam int FFME_DATA_W      = 14;

endpackage

// ---- freefall_motion_event_status_tb.sv ----
// freefall_motion_event_status_tb: register and event checks of the freefall/motion block.
// assumes ffme_host as register master; samples and interrupt bits come from here.
`timescale 1ns/10ps
module freefall_motion_event_status_tb;
  import ffme_pkg::*;
  logic                    core_clk = 1'b0;
  logic                    rst_b = 1'b0;
  logic                    sample_valid = 1'b0;
  logic signed [13:0]      accel_x = 14'h0000;
  logic signed [13:0]      accel_y = 14'h0000;
  logic signed [13:0]      accel_z = 14'h0000;
  logic                    int_enable = 1'b1;
  logic                    int_route = 1'b1;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [7:0]              reg_addr;
  logic [7:0]              reg_wdata;
  logic [7:0]              reg_rdata;
  logic                    irq_int1;
  logic                    irq_int2;
  logic                    event_active_flag;
  int                      num_errors = 0;
  int                      samples_checked = 0;
  logic [7:0]              offs [11] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h73, 8'h74,
                                         8'h75, 8'h76, 8'h77, 8'h78, 8'h20};

  always #5 core_clk = ~core_clk;

  ffme_event ffme_event_i (.core_clk(core_clk), .rst_b(rst_b), .sample_valid(sample_valid),
    .accel_x(accel_x), .accel_y(accel_y), .accel_z(accel_z), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .int_enable(int_enable),
    .int_route(int_route), .reg_rdata(reg_rdata), .irq_int1(irq_int1),
    .irq_int2(irq_int2), .event_active_flag(event_active_flag));

  ffme_host ffme_host_i (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    ffme_host_i.acc(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    ffme_host_i.acc(1'b0, a, 8'h00, q);
    samples_checked++;
    if (q !== exp) begin
      num_errors++;
      $display("ERROR t=%0t read %h got %h want %h", $time, a, q, exp);
    end
  endtask

  task automatic chk_pins(input logic ea, input logic i1, input logic i2);
    samples_checked++;
    if ({event_active_flag, irq_int1, irq_int2} !== {ea, i1, i2}) begin
      num_errors++;
      $display("ERROR t=%0t pins %b%b%b want %b%b%b", $time, event_active_flag,
               irq_int1, irq_int2, ea, i1, i2);
    end
  endtask

  task automatic smp(input logic signed [13:0] x, y, z);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    accel_x <= x;
    accel_y <= y;
    accel_z <= z;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    accel_x <= ~x;
    accel_y <= ~y;
    accel_z <= ~z;
    #1;
  endtask

  // x-only pattern: match, match, miss, match, match against a threshold of 64
  task automatic pat();
    logic [4:0] p;
    p = 5'b11011;
    for (int i = 4; i >= 0; i--) begin
      smp(p[i] ? 14'sd100 : 14'sd10, 14'sd0, 14'sd0);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (offs[i]) rd_chk(offs[i], 8'h00);
    wr(8'h17, 8'h85);
    rd_chk(8'h17, 8'h85);
    wr(8'h16, 8'hff);
    rd_chk(8'h16, 8'h00);
    // motion on x only; y and z far above threshold but disabled
    wr(8'h15, 8'h48);
    wr(8'h18, 8'h02);
    wr(8'h17, 8'h01);
    smp(-14'sd100, 14'sd5000, -14'sd5000);
    chk_pins(1'b0, 1'b0, 1'b0);
    smp(-14'sd100, 14'sd5000, -14'sd5000);
    chk_pins(1'b1, 1'b1, 1'b0);
    rd_chk(8'h16, 8'h83);
    @(posedge core_clk) int_route <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk_pins(1'b1, 1'b0, 1'b1);
    @(posedge core_clk) int_enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk_pins(1'b1, 1'b0, 1'b0);
    @(posedge core_clk);
    int_enable <= 1'b1;
    int_route <= 1'b1;
    // freefall needs every enabled axis below threshold
    wr(8'h15, 8'h38);
    wr(8'h18, 8'h00);
    smp(14'sd10, -14'sd10, 14'sd10);
    chk_pins(1'b1, 1'b1, 1'b0);
    rd_chk(8'h16, 8'hae);
    smp(14'sd10, -14'sd10, 14'sd5000);
    chk_pins(1'b0, 1'b0, 1'b0);
    // clear mode one zeroes the count on a miss, mode zero only steps it down
    wr(8'h15, 8'h48);
    wr(8'h18, 8'h03);
    wr(8'h17, 8'h81);
    smp(14'sd10, 14'sd0, 14'sd0);
    pat();
    chk_pins(1'b0, 1'b0, 1'b0);
    wr(8'h17, 8'h01);
    repeat (3) smp(14'sd10, 14'sd0, 14'sd0);
    pat();
    chk_pins(1'b1, 1'b1, 1'b0);
    // per-axis x threshold 200 overrides the common 64
    wr(8'h18, 8'h00);
    wr(8'h73, 8'h83);
    wr(8'h74, 8'h20);
    rd_chk(8'h73, 8'h83);
    smp(14'sd100, 14'sd0, 14'sd0);
    chk_pins(1'b0, 1'b0, 1'b0);
    smp(14'sd300, 14'sd0, 14'sd0);
    chk_pins(1'b1, 1'b1, 1'b0);
    wr(8'h73, 8'h00);
    smp(14'sd100, 14'sd0, 14'sd0);
    chk_pins(1'b1, 1'b1, 1'b0);
    // latched flags freeze on event and clear on a source read
    wr(8'h15, 8'hc8);
    wr(8'h73, 8'h83);
    smp(14'sd300, 14'sd0, 14'sd0);
    smp(14'sd10, 14'sd0, 14'sd0);
    chk_pins(1'b1, 1'b1, 1'b0);
    rd_chk(8'h16, 8'h82);
    chk_pins(1'b0, 1'b0, 1'b0);
    rd_chk(8'h16, 8'h00);
    // a sample taken in the clearing read cycle still lands
    smp(14'sd300, 14'sd0, 14'sd0);
    fork
      smp(-14'sd300, 14'sd0, 14'sd0);
      rd_chk(8'h16, 8'h82);
    join
    chk_pins(1'b1, 1'b1, 1'b0);
    rd_chk(8'h16, 8'h83);
    report_and_stop();
  end
endmodule
